// ### hlt_pkg.sv
// Constants shared by the hardware limit timer and its scaler modules
package hlt_pkg;
    // ==========================================================
    // Widths
    localparam int CNT_W      = 8;          // Limit counter and period
    localparam int PRE_SEL_W  = 2;          // Prescale select field
    localparam int POST_SEL_W = 4;          // Postscale select field
    localparam int SRC_SEL_W  = 3;          // Reset source select field
    localparam int PRESC_W    = 4;          // Prescaler counter
    localparam int INSTR_W    = 2;          // Core clock to instruction clock
    // ==========================================================
    // Reset values
    localparam logic [7:0] CNT_RST    = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;
    localparam logic [6:0] CTRL0_RST  = 7'h00;
    localparam logic [4:0] CTRL1_RST  = 5'h00;
    // ==========================================================
    // Instruction clock: one tick per four core clocks
    localparam logic [1:0] INSTR_LAST = 2'h3;
    // ==========================================================
    // Control register 0 field positions
    localparam int C0_PRE_LSB  = 0;
    localparam int C0_ON_BIT   = 2;
    localparam int C0_POST_LSB = 3;
    // Control register 1 field positions
    localparam int C1_RISE_BIT = 0;
    localparam int C1_FALL_BIT = 1;
    localparam int C1_SRC_LSB  = 2;
    // ==========================================================
    // Prescale codes; 2'h2 and 2'h3 both divide by 16
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    localparam logic [3:0] PRE_LAST4  = 4'h3;
    localparam logic [3:0] PRE_LAST16 = 4'hf;
    // ==========================================================
    // Reset source codes; all others are reserved
    localparam logic [2:0] SRC_CCP  = 3'h1;
    localparam logic [2:0] SRC_CMP1 = 3'h2;
    localparam logic [2:0] SRC_CMP2 = 3'h3;
endpackage : hlt_pkg

// ### hlt_scale_if.sv
// Signals between the timer core and its prescaler and postscaler
`timescale 1ns/1ps
interface hlt_scale_if;
    logic       run;       // Timer on and processor awake
    logic       clr;       // Clear both scaler counters
    logic [1:0] pre_sel;   // Prescale select
    logic [3:0] post_sel;  // Postscale select
    logic       tick;      // Prescaled timer clock pulse
    logic       match;     // Counter match pulse
    logic       ovf;       // Postscaler overflow pulse
    modport presc (input run, clr, pre_sel, output tick);
    modport post  (input clr, match, post_sel, output ovf);
    modport core  (output run, clr, pre_sel, post_sel, match, input tick, ovf);
endinterface : hlt_scale_if

// ### hlt_prescaler.sv
// Instruction clock divider and selectable timer prescaler
`timescale 1ns/1ps
module hlt_prescaler
    import hlt_pkg::*;
(
    input  wire logic  core_clk_i,
    input  wire logic  nrst_i,
    hlt_scale_if.presc sc
);
    // ==========================================================
    // State
    logic [INSTR_W-1:0] quarter_ff;  // Core clock phase
    logic [PRESC_W-1:0] presc_ff;    // Prescaler count
    logic               tick_ff;     // Registered timer tick
    logic               base_tick;   // Instruction clock edge

    // Terminal count for the selected ratio
    function automatic logic presc_term(input logic [1:0] sel, input logic [3:0] cnt);
        case (sel)
            PRE_DIV1: presc_term = 1'b1;
            PRE_DIV4: presc_term = (cnt[1:0] == PRE_LAST4[1:0]);
            default:  presc_term = (cnt == PRE_LAST16);
        endcase
    endfunction : presc_term

    // Frozen in sleep or when off, so no stray edge
    assign base_tick = sc.run && (quarter_ff == INSTR_LAST);

    // Divide core clock by four
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            quarter_ff <= '0;
        end else if (sc.run) begin
            quarter_ff <= quarter_ff + 2'h1;
        end
    end

    // Prescaler counter, cleared by counter and control 0 writes and resets
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            presc_ff <= '0;
            tick_ff  <= 1'b0;
        end else if (sc.clr) begin
            presc_ff <= '0;
            tick_ff  <= 1'b0;
        end else begin
            tick_ff <= base_tick && presc_term(sc.pre_sel, presc_ff);
            if (base_tick) begin
                presc_ff <= presc_ff + 4'h1;
            end
        end
    end

    assign sc.tick = tick_ff;

    // Direct input passes every instruction tick
    a_div1_direct: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        base_tick && sc.pre_sel == PRE_DIV1 && !sc.clr |=> tick_ff)
        else $error("direct prescale missed a tick");
endmodule : hlt_prescaler

// ### hlt_postscaler.sv
// Match postscaler that signals overflow at the selected ratio
`timescale 1ns/1ps
module hlt_postscaler
    import hlt_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    hlt_scale_if.post sc
);
    // ==========================================================
    // State
    logic [POST_SEL_W-1:0] post_ff;  // Matches seen
    logic                  ovf_ff;   // Overflow pulse

    // Count matches, overflow when count equals select
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            post_ff <= '0;
            ovf_ff  <= 1'b0;
        end else if (sc.clr) begin
            post_ff <= '0;
            ovf_ff  <= 1'b0;
        end else if (sc.match) begin
            if (post_ff == sc.post_sel) begin
                post_ff <= '0;
                ovf_ff  <= 1'b1;
            end else begin
                post_ff <= post_ff + 4'h1;
                ovf_ff  <= 1'b0;
            end
        end else begin
            ovf_ff <= 1'b0;
        end
    end

    assign sc.ovf = ovf_ff;

    // Ratio 1:1 overflows on every match
    a_post_ratio1: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        sc.match && !sc.clr && sc.post_sel == 4'h0 |=> ovf_ff)
        else $error("1:1 postscale missed overflow");
endmodule : hlt_postscaler

// ### hlt_limit_timer.sv
// Hardware limit timer: 8-bit period timer with external counter reset
`timescale 1ns/1ps

// Notes on behaviour
// - Counter advances on prescaled instruction clock
// - Prescaler offers direct, divide 4, divide 16
// - Counter compared with period every tick
// - Match clears counter, advances postscaler
// - Pulse after period plus one ticks
// - Reset clears counter, period loads all ones
// - Counter and control 0 writes and resets clear both scalers
// - Control 0 write keeps counter value
// - Postscaler overflow sets the match flag
// - Interrupt forwarded only while enabled
// - Three-bit field selects reset source
// - External reset clears on next tick
// - Rising and falling resets enabled separately
// - External clear gives no pulse, no postscale
// - Match pulse goes to output generator and postscaler
// - Timer frozen while processor sleeps
// - Counter and period writable any time
module hlt_limit_timer
    import hlt_pkg::*;
(
    input  wire logic       core_clk_i,             // Oscillator clock, 40 MHz
    input  wire logic       nrst_i,                 // Power-on reset, async
    input  wire logic       dev_rst_i,              // Any other device reset
    input  wire logic       sleep_i,                // Processor in sleep
    input  wire logic [7:0] wdata_i,                // Write data for all registers
    input  wire logic       limit_counter_wr_i,     // Write counter
    input  wire logic       limit_period_wr_i,      // Write period
    input  wire logic       limit_ctrl0_wr_i,       // Write control 0
    input  wire logic       limit_ctrl1_wr_i,       // Write control 1
    input  wire logic       limit_match_irq_en_i,   // Interrupt enable bit
    input  wire logic       limit_match_flag_clr_i, // Software clears flag
    input  wire logic       ccp_out_i,              // Capture/compare output
    input  wire logic       cmp1_out_i,             // Comparator 1 output
    input  wire logic       cmp2_out_i,             // Comparator 2 output
    output logic      [7:0] limit_counter_o,        // Counter readback
    output logic      [7:0] limit_period_o,         // Period readback
    output logic      [7:0] limit_ctrl0_o,          // Control 0 readback
    output logic      [7:0] limit_ctrl1_o,          // Control 1 readback
    output logic            limit_match_o,          // Unscaled match pulse
    output logic            limit_match_flag_o,     // Sticky interrupt flag
    output logic            limit_irq_o             // Gated interrupt request
);

    // ==========================================================
    // Registers
    logic [CNT_W-1:0] limit_counter_ff;  // Running count
    logic [CNT_W-1:0] limit_period_ff;   // Match value
    logic [6:0]       limit_ctrl0_ff;    // Postscale, on, prescale
    logic [4:0]       limit_ctrl1_ff;    // Source, fall and rise enables
    logic             match_ff;          // Match pulse to generator
    logic             flag_ff;           // Sticky match flag
    logic             irq_ff;            // Interrupt request
    logic             pend_ff;           // External reset waiting for tick

    // ==========================================================
    // Reset source synchronisers
    logic [2:0]       src_s1_ff;         // First stage, feeds second only
    logic [2:0]       src_s2_ff;         // Second stage, safe to use
    logic             src_prev_ff;       // Selected source, last cycle

    // ==========================================================
    // Decoded fields and internal strobes
    logic [PRE_SEL_W-1:0]  limit_prescale_sel;    // Prescale field
    logic [POST_SEL_W-1:0] limit_postscale_sel;   // Postscale field
    logic                  limit_timer_on;        // Timer on bit
    logic [SRC_SEL_W-1:0]  ext_reset_source_sel;  // Source field
    logic                  rise_reset_en;         // Rising edge enable
    logic                  fall_reset_en;         // Falling edge enable
    logic                  src_now;               // Selected source level
    logic                  ext_edge;              // Enabled edge seen
    logic                  run;                   // Timer may count
    logic                  scaler_clr;            // Clear both scalers
    logic                  run_tick;              // Counting edge
    logic                  hit;                   // Match on this tick

    // Scaler connection
    hlt_scale_if sc ();

    // ==========================================================
    // Field decode
    assign limit_prescale_sel   = limit_ctrl0_ff[C0_PRE_LSB +: PRE_SEL_W];
    assign limit_timer_on       = limit_ctrl0_ff[C0_ON_BIT];
    assign limit_postscale_sel  = limit_ctrl0_ff[C0_POST_LSB +: POST_SEL_W];
    assign rise_reset_en        = limit_ctrl1_ff[C1_RISE_BIT];
    assign fall_reset_en        = limit_ctrl1_ff[C1_FALL_BIT];
    assign ext_reset_source_sel = limit_ctrl1_ff[C1_SRC_LSB +: SRC_SEL_W];

    // Source select; reserved codes read as a steady low
    function automatic logic src_pick(input logic [2:0] sel, input logic [2:0] lvl);
        case (sel)
            SRC_CCP:  src_pick = lvl[0];
            SRC_CMP1: src_pick = lvl[1];
            SRC_CMP2: src_pick = lvl[2];
            default:  src_pick = 1'b0;
        endcase
    endfunction : src_pick

    // ==========================================================
    // Run and clear terms
    // Sleep and timer off both stop the clock path
    assign run        = limit_timer_on && !sleep_i;
    // Counter write, control 0 write, any reset
    assign scaler_clr = limit_counter_wr_i || limit_ctrl0_wr_i || dev_rst_i;
    // A clearing cycle swallows the tick, so a control 0 write
    // cannot move the counter either
    assign run_tick   = sc.tick && run && !scaler_clr;
    // Compare on each tick; pending external reset takes priority
    assign hit        = run_tick && !pend_ff && (limit_counter_ff == limit_period_ff);

    assign sc.run      = run;
    assign sc.clr      = scaler_clr;
    assign sc.pre_sel  = limit_prescale_sel;
    assign sc.post_sel = limit_postscale_sel;
    assign sc.match    = match_ff;

    // ==========================================================
    // Scalers
    hlt_prescaler u_presc (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sc         (sc.presc)
    );

    hlt_postscaler u_post (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sc         (sc.post)
    );

    // ==========================================================
    // Control registers
    // Plain storage; their clearing side effects live elsewhere
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            limit_ctrl0_ff <= CTRL0_RST;
            limit_ctrl1_ff <= CTRL1_RST;
        end else if (dev_rst_i) begin
            limit_ctrl0_ff <= CTRL0_RST;
            limit_ctrl1_ff <= CTRL1_RST;
        end else begin
            if (limit_ctrl0_wr_i) begin
                limit_ctrl0_ff <= wdata_i[6:0];
            end
            if (limit_ctrl1_wr_i) begin
                limit_ctrl1_ff <= wdata_i[4:0];
            end
        end
    end

    // Period register, all ones after any reset
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            limit_period_ff <= PERIOD_RST;
        end else if (dev_rst_i) begin
            limit_period_ff <= PERIOD_RST;
        end else if (limit_period_wr_i) begin
            limit_period_ff <= wdata_i;
        end
    end

    // ==========================================================
    // Reset source synchroniser
    // Comparator outputs are asynchronous; two stages before use
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_s1_ff <= 3'h0;
            src_s2_ff <= 3'h0;
        end else begin
            src_s1_ff <= {cmp2_out_i, cmp1_out_i, ccp_out_i};
            src_s2_ff <= src_s1_ff;
        end
    end

    // Edge detect on the selected, synchronised source
    assign src_now  = src_pick(ext_reset_source_sel, src_s2_ff);
    // Each direction has its own enable
    assign ext_edge = limit_timer_on &&
                      ((rise_reset_en && src_now && !src_prev_ff) ||
                       (fall_reset_en && !src_now && src_prev_ff));

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_prev_ff <= 1'b0;
        end else begin
            src_prev_ff <= src_now;
        end
    end

    // Event waits for the next timer tick; a new edge wins over the
    // consuming tick so none is lost
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_ff <= 1'b0;
        end else if (dev_rst_i) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= ext_edge || (pend_ff && !run_tick);
        end
    end

    // ==========================================================
    // Limit counter
    // Write wins over a tick; reset wins over all
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            limit_counter_ff <= CNT_RST;
        end else if (dev_rst_i) begin
            limit_counter_ff <= CNT_RST;
        end else if (limit_counter_wr_i) begin
            limit_counter_ff <= wdata_i;
        end else if (run_tick) begin
            if (pend_ff) begin
                limit_counter_ff <= CNT_RST;
            end else if (hit) begin
                limit_counter_ff <= CNT_RST;
            end else begin
                limit_counter_ff <= limit_counter_ff + 8'h01;
            end
        end
    end

    // ==========================================================
    // Match pulse, one core clock wide, on the clearing tick.
    // Counting the clearing tick, period plus one ticks pass from a
    // counter clear to the pulse
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            match_ff <= 1'b0;
        end else begin
            match_ff <= hit && !limit_counter_wr_i && !dev_rst_i;
        end
    end

    // ==========================================================
    // Flag and interrupt
    // Overflow set wins over a software clear in the same cycle
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_ff <= 1'b0;
        end else if (dev_rst_i) begin
            flag_ff <= 1'b0;
        end else if (sc.ovf) begin
            flag_ff <= 1'b1;
        end else if (limit_match_flag_clr_i) begin
            flag_ff <= 1'b0;
        end
    end

    // Request only while enabled
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= flag_ff && limit_match_irq_en_i;
        end
    end

    // ==========================================================
    // Outputs
    assign limit_counter_o    = limit_counter_ff;
    assign limit_period_o     = limit_period_ff;
    assign limit_ctrl0_o      = {1'b0, limit_ctrl0_ff};
    assign limit_ctrl1_o      = {3'h0, limit_ctrl1_ff};
    assign limit_match_o      = match_ff;   // Generator only
    assign limit_match_flag_o = flag_ff;
    assign limit_irq_o        = irq_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // First cycle after release marker
    logic seen_ff;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seen_ff <= 1'b0;
        end else begin
            seen_ff <= 1'b1;
        end
    end

    // All checks are blind while power-on reset is low
    a_reset_values: assert property (
        !seen_ff |-> limit_counter_ff == CNT_RST && limit_period_ff == PERIOD_RST)
        else $error("reset values wrong");
    a_count_advance: assert property (
        run_tick && !pend_ff && !hit && !limit_counter_wr_i && !dev_rst_i
        |=> limit_counter_ff == $past(limit_counter_ff) + 8'h01)
        else $error("counter did not advance");
    a_match_clears: assert property (
        hit && !limit_counter_wr_i && !dev_rst_i
        |=> limit_counter_ff == CNT_RST && match_ff)
        else $error("match did not clear and pulse");
    a_ext_no_pulse: assert property (
        run_tick && pend_ff && !limit_counter_wr_i && !dev_rst_i
        |=> limit_counter_ff == CNT_RST && !match_ff)
        else $error("external clear misbehaved");
    a_ctrl0_keeps_count: assert property (
        limit_ctrl0_wr_i && !limit_counter_wr_i && !dev_rst_i
        |=> $stable(limit_counter_ff))
        else $error("control write moved counter");
    a_sleep_freeze: assert property (
        sleep_i && !limit_counter_wr_i && !dev_rst_i |=> $stable(limit_counter_ff))
        else $error("counter moved in sleep");
    a_off_holds: assert property (
        !limit_timer_on && !limit_counter_wr_i && !dev_rst_i
        |=> $stable(limit_counter_ff) && !match_ff)
        else $error("timer off but active");
    a_irq_gated: assert property (
        !limit_match_irq_en_i |=> !limit_irq_o)
        else $error("interrupt passed while disabled");
    // Set lands next cycle; only a clear or reset in that cycle may drop it
    a_flag_sets: assert property (
        sc.ovf && !dev_rst_i
        |=> flag_ff
        ##1 (flag_ff || $past(limit_match_flag_clr_i) || $past(dev_rst_i)))
        else $error("flag not set by overflow");
    a_counter_write: assert property (
        limit_counter_wr_i && !dev_rst_i |=> limit_counter_ff == $past(wdata_i))
        else $error("counter write lost");
    a_edge_pends: assert property (
        ext_edge && !dev_rst_i |=> pend_ff)
        else $error("external edge lost");

    c_match:  cover property (match_ff);
    c_ext:    cover property (run_tick && pend_ff);
    c_flag:   cover property (!flag_ff ##1 flag_ff);
    c_irq:    cover property (limit_irq_o);
    // Longest postscale ratio reaching overflow
    c_post16: cover property (sc.ovf && limit_postscale_sel == 4'hf);
endmodule : hlt_limit_timer

// ### hlt_fb_model.sv
// Analog feedback model: toggles the selected reset source on request
`timescale 1ns/1ps
module hlt_fb_model (
    input  wire logic       core_clk_i,
    input  wire logic [1:0] src_i,      // 1 capture/compare, 2 comp1, 3 comp2
    input  wire logic       flip_i,     // One-cycle toggle request
    output logic            ccp_o,
    output logic            cmp1_o,
    output logic            cmp2_o
);
    initial {ccp_o, cmp1_o, cmp2_o} = 3'h0;
    // Bench spaces flips well inside the period, as software must
    always @(posedge core_clk_i) begin
        if (flip_i && src_i == 2'h1) ccp_o <= ~ccp_o;
        if (flip_i && src_i == 2'h2) cmp1_o <= ~cmp1_o;
        if (flip_i && src_i == 2'h3) cmp2_o <= ~cmp2_o;
    end
endmodule : hlt_fb_model

// ### hardware_limit_timer_bench.sv
// Self-checking bench for the hardware limit timer
`timescale 1ns/1ps
module hardware_limit_timer_bench;
    import hlt_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    logic       core_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       dev_rst = 1'b0;
    logic       sleep = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [3:0] wr = 4'h0;      // Counter, period, ctrl0, ctrl1
    logic       irq_en = 1'b0;
    logic       fclr = 1'b0;    // Flag clear pulse
    logic [1:0] fsrc = 2'h0;    // Feedback source that toggles
    logic       flip = 1'b0;
    logic       ccp, cmp1, cmp2, match, flag, irq;
    logic [7:0] cnt, per, c0, c1;
    // Table: expect match, model source, code, fall, rise
    logic [7:0] cfg [5] = '{8'h25, 8'h4a, 8'h6f, 8'hb7, 8'ha4};
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int last = 0;
    int seed = 32'hff22c3e7;
    int exp_q[$];               // Expected gaps between match pulses
    int p, s, n;
    bit hit;
    always #12.5 core_clk = ~core_clk;
    hlt_limit_timer hlt_limit_timer_inst (.core_clk_i(core_clk), .nrst_i(nrst),
        .dev_rst_i(dev_rst), .sleep_i(sleep), .wdata_i(wdata),
        .limit_counter_wr_i(wr[3]), .limit_period_wr_i(wr[2]),
        .limit_ctrl0_wr_i(wr[1]), .limit_ctrl1_wr_i(wr[0]),
        .limit_match_irq_en_i(irq_en), .limit_match_flag_clr_i(fclr),
        .ccp_out_i(ccp), .cmp1_out_i(cmp1), .cmp2_out_i(cmp2),
        .limit_counter_o(cnt), .limit_period_o(per), .limit_ctrl0_o(c0),
        .limit_ctrl1_o(c1), .limit_match_o(match), .limit_match_flag_o(flag),
        .limit_irq_o(irq));
    hlt_fb_model hlt_fb_model_inst (.core_clk_i(core_clk), .src_i(fsrc),
        .flip_i(flip), .ccp_o(ccp), .cmp1_o(cmp1), .cmp2_o(cmp2));
    // ==========================================
    // Tasks
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
        end
    endtask : check
    task automatic step(input int k);
        repeat (k) @(negedge core_clk);
    endtask : step
    // Register write: r 0 counter, 1 period, 2 ctrl0, 3 ctrl1
    task automatic put(input int r, input logic [7:0] d);
        step(1);
        wdata = d;
        wr = 4'h8 >> r;
        step(1);
        wr = 4'h0;
    endtask : put
    task automatic wait_match(input int lim);
        hit = 1'b0;
        for (int k = 0; k < lim && !hit; k++) begin
            step(1);
            hit = (match === 1'b1);
        end
    endtask : wait_match
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // Monitor: gap between match pulses against the oldest note; timeout
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 30000) begin
            failures++;
            tally_and_finish();
        end
        if (match === 1'b1) begin
            if (exp_q.size() > 0) check("match gap", exp_q.pop_front(), cyc - last);
            last = cyc;
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        step(5);
        nrst = 1'b1;
        check("counter", 8'h00, cnt);
        check("period", 8'hff, per);
        // Match spacing for every prescale code
        for (p = 0; p < 4; p++) begin
            n = ($random(seed) & 15) + 1;
            put(1, n[7:0]);
            check("period", n, per);
            put(2, {5'h01, p[1:0]});
            check("ctrl0", {5'h01, p[1:0]}, c0);
            put(0, 8'h00);
            wait_match(2000);
            step(1);    // Monitor must take this pulse as the start, not a gap
            exp_q.push_back((n + 1) * 4 * (p == 0 ? 1 : p == 1 ? 4 : 16));
            wait_match(2000);
            check("match seen", 1, hit);
        end
        // Postscaler ratios and gated request
        for (p = 0; p < 3; p++) begin
            s = (p == 0) ? 0 : (p == 1) ? 15 : ($random(seed) & 15);
            irq_en = $random(seed);
            put(1, 8'h01);
            put(2, {1'b0, s[3:0], 3'h4});
            put(0, 8'h00);
            fclr = 1'b1;
            step(1);
            fclr = 1'b0;
            n = 0;
            for (int k = 0; k < 400 && flag !== 1'b1; k++) begin
                step(1);
                if (match === 1'b1) n++;
            end
            check("matches to flag", s + 1, n);
            step(2);
            check("irq", irq_en, irq);
        end
        // Timer off, ctrl0 rewrite, then sleep: counter held
        put(2, 8'h00);
        put(0, 8'h5a);
        put(2, 8'h03);
        step(40);
        check("counter off", 8'h5a, cnt);
        sleep = 1'b1;
        put(2, 8'h04);
        step(40);
        check("counter asleep", 8'h5a, cnt);
        sleep = 1'b0;
        // External resets: sources, edge enables, a reserved code
        for (p = 0; p < 5; p++) begin
            put(1, 8'hff);
            put(3, {3'h0, cfg[p][4:0]});
            check("ctrl1", {3'h0, cfg[p][4:0]}, c1);
            put(2, 8'h04);
            put(0, 8'h00);
            fclr = 1'b1;
            step(1);
            fclr = 1'b0;
            fsrc = cfg[p][6:5];
            n = 0;
            for (int k = 0; k < 1400; k++) begin
                flip = (k % 40 == 0);
                step(1);
                if (match === 1'b1) n++;
            end
            check("match after ext", cfg[p][7], n > 0);
            check("flag after ext", cfg[p][7], flag);
        end
        // Device reset: period back to all ones, control 0 and counter cleared
        dev_rst = 1'b1;
        step(1);
        dev_rst = 1'b0;
        check("period", 8'hff, per);
        check("ctrl0", 8'h00, c0);
        check("counter", 8'h00, cnt);
        tally_and_finish();
    end
endmodule : hardware_limit_timer_bench
